// file: rtl/sam_core.sv
// Split-address mux bus-cycle logic with Wishbone register port
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ns
module sam_core (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Host bus pins
  input  wire logic        clk_edge_i,
  input  wire logic        address_valid_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        ce_n_i,
  input  wire logic [15:0] ad_i,
  output logic      [15:0] ad_o,
  output logic             ad_oe_o,
  output logic             wait_o,
  output logic             wait_oe_o,
  // Array side
  input  wire logic [15:0] array_data_i,
  output logic      [31:0] array_addr_o,
  output logic             sense_start_o,
  output logic             write_strobe_o,
  output logic      [15:0] write_data_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_SENSE, ST_BURST} sam_state_t;

  sam_pkg::sam_bus_t  bus;
  sam_state_t         state_reg;
  logic [15:0]        cfg_reg;
  logic [15:0]        upper_reg;
  logic [15:0]        lower_reg;
  logic               adv_d_reg;
  logic               we_d_reg;
  logic               lat_lower;
  logic               lat_upper;
  logic               sync_mode;
  logic               mode_en;
  logic               sense_busy;
  logic               sense_done;
  logic               data_ok_reg;
  logic [1:0]         eowl_reg;
  logic               wait_act;
  logic               wb_hit;
  logic               ack_reg;
  logic [31:0]        rd_next;

  assign bus = '{adv_n: address_valid_n_i, oe_n: oe_n_i, we_n: we_n_i,
                 ce_n: ce_n_i, clk_rise: clk_edge_i, ad: ad_i};
  assign sync_mode = ~cfg_reg[sam_pkg::SAM_CFG_SYNC_N_BIT];
  assign mode_en   = cfg_reg[sam_pkg::SAM_CFG_MODE_BIT];

  // Edge history of the host strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_d_reg <= 1'b1;
      we_d_reg  <= 1'b1;
    end else begin
      adv_d_reg <= bus.adv_n;
      we_d_reg  <= bus.we_n;
    end
  end

  // Address capture: async on valid rise, sync on CLK rise while valid low
  logic cap;
  always_comb begin
    if (sync_mode) begin
      cap = ~bus.ce_n & ~bus.adv_n & bus.clk_rise;
    end else begin
      cap = ~bus.ce_n & bus.adv_n & ~adv_d_reg;
    end
  end
  assign lat_upper = cap & mode_en & ~bus.oe_n;
  assign lat_lower = cap & bus.oe_n;

  // Upper address survives across cycles that skip it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_reg <= 16'h0000;
    end else if (wb_hit && we_i && adr_i == sam_pkg::SAM_CFG_OFS &&
                 sel_i[0] && dat_i[sam_pkg::SAM_CFG_MODE_BIT] &&
                 !mode_en) begin
      upper_reg <= 16'h0000;
    end else if (lat_upper) begin
      upper_reg <= bus.ad;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lower_reg <= 16'h0000;
    end else if (lat_lower) begin
      lower_reg <= bus.ad;
    end
  end

  // Plain mux mode ignores the stored upper half
  assign array_addr_o = {mode_en ? upper_reg : 16'h0000, lower_reg};

  // Sensing begins as the lower address is latched, reads only
  assign sense_start_o = lat_lower & bus.we_n;

  sam_sense #(
    .CYC(sam_pkg::SAM_SENSE_CYC)
  ) u_sense (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .start_i(sense_start_o),
    .busy_o (sense_busy),
    .done_o (sense_done)
  );

  // Write commits on write-enable rise, regardless of CLK
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_strobe_o <= 1'b0;
      write_data_o   <= 16'h0000;
    end else begin
      write_strobe_o <= ~bus.ce_n & bus.we_n & ~we_d_reg;
      if (~bus.ce_n & bus.we_n & ~we_d_reg) begin
        write_data_o <= bus.ad;
      end
    end
  end

  // Read state: sense, then stream words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:  if (sense_start_o) state_reg <= ST_SENSE;
        // A new address phase ends the read, so no drive during it
        ST_SENSE: if (!bus.adv_n) state_reg <= ST_IDLE;
                  else if (sense_done) state_reg <= ST_BURST;
        ST_BURST: if (bus.ce_n || !bus.adv_n || sense_start_o)
                    state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Wordline crossing in a burst costs extra wait states
  logic [3:0] burst_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_cnt_reg <= 4'h0;
      eowl_reg      <= 2'b00;
    end else if (state_reg != ST_BURST) begin
      burst_cnt_reg <= lower_reg[3:0];
      eowl_reg      <= 2'b00;
    end else if (eowl_reg != 2'b00) begin
      eowl_reg <= eowl_reg - 2'b01;
    end else if (sync_mode && bus.clk_rise && ~bus.oe_n) begin
      burst_cnt_reg <= burst_cnt_reg + 4'h1;
      if (burst_cnt_reg == 4'hf) begin
        eowl_reg <= 2'(sam_pkg::SAM_EOWL_WAIT);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_ok_reg <= 1'b0;
    end else begin
      data_ok_reg <= (state_reg == ST_BURST) && (eowl_reg == 2'b00);
    end
  end

  // Output data and wait; wait driven with the data bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ad_o <= 16'h0000;
    end else if (state_reg == ST_BURST) begin
      ad_o <= array_data_i;
    end
  end

  always_comb begin
    if (!sync_mode) begin
      wait_act = 1'b0;
    end else if (cfg_reg[sam_pkg::SAM_CFG_WTIME_BIT]) begin
      wait_act = (state_reg != ST_BURST) || (eowl_reg != 2'b00);
    end else begin
      wait_act = ~data_ok_reg;
    end
  end

  assign ad_oe_o   = ~bus.ce_n & ~bus.oe_n & bus.adv_n & bus.we_n &
                     (state_reg != ST_IDLE);
  assign wait_oe_o = ad_oe_o;
  // Polarity bit 0 means active low
  assign wait_o    = cfg_reg[sam_pkg::SAM_CFG_WPOL_BIT] ? wait_act
                                                       : ~wait_act;

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wb_hit = cyc_i & stb_i & ~ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= sam_pkg::SAM_CFG_RESET;
    end else if (wb_hit && we_i && adr_i == sam_pkg::SAM_CFG_OFS) begin
      if (sel_i[0]) cfg_reg[7:0]  <= dat_i[7:0];
      if (sel_i[1]) cfg_reg[15:8] <= dat_i[15:8];
    end
  end

  always_comb begin
    case (adr_i)
      sam_pkg::SAM_CFG_OFS:   rd_next = {16'h0000, cfg_reg};
      sam_pkg::SAM_UPPER_OFS: rd_next = {16'h0000, upper_reg};
      sam_pkg::SAM_ADDR_OFS:  rd_next = array_addr_o;
      sam_pkg::SAM_STAT_OFS:  rd_next = {28'h0000000, sense_busy,
                                         state_reg == ST_BURST, sync_mode,
                                         mode_en};
      default:                rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o   <= 32'h00000000;
    end else begin
      ack_reg <= wb_hit;
      if (wb_hit) dat_o <= rd_next;
    end
  end
  assign ack_o = ack_reg;

  // Checks
  upper_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !lat_upper && !$rose(mode_en) |=> $stable(upper_reg))
    else $error("upper address changed without capture");
  lower_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lat_lower && !lat_upper && !$rose(mode_en) |=>
      lower_reg == $past(bus.ad) && $stable(upper_reg))
    else $error("single phase disturbed upper");
  sync_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_mode && lat_lower |-> bus.clk_rise && !bus.adv_n)
    else $error("sync capture off clock");
  upper_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lat_upper |-> !bus.oe_n && mode_en)
    else $error("upper captured with oe high");
  sense_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_start_o |=> sense_busy)
    else $error("sensing not started on lower latch");
  wr_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus.ce_n && bus.we_n && !we_d_reg |=>
      write_strobe_o && write_data_o == $past(bus.ad))
    else $error("write not committed on we rise");
  wait_drv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_oe_o == ad_oe_o)
    else $error("wait drive differs from data drive");
  mode_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mode_en) |-> upper_reg == 16'h0000)
    else $error("upper not zero on mode entry");
  eowl_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_BURST && eowl_reg != 2'b00 && sync_mode |->
      wait_act)
    else $error("wordline wait not shown");
  sync_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_mode && write_strobe_o |-> $past(bus.we_n) && !$past(we_d_reg))
    else $error("sync write not on we rise");
endmodule

// file: rtl/sam_pkg.sv
// Package: constants and carriers for the split-address mux bus logic
package sam_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] SAM_CFG_OFS    = 4'h0;
  localparam logic [3:0] SAM_UPPER_OFS  = 4'h4;
  localparam logic [3:0] SAM_ADDR_OFS   = 4'h8;
  localparam logic [3:0] SAM_STAT_OFS   = 4'hc;
  // Read configuration field positions
  localparam int SAM_CFG_SYNC_N_BIT = 15;
  localparam int SAM_CFG_WPOL_BIT   = 10;
  localparam int SAM_CFG_WTIME_BIT  = 8;
  localparam int SAM_CFG_MODE_BIT   = 4;
  localparam logic [15:0] SAM_CFG_RESET = 16'h8000;
  // Address widths
  localparam int SAM_LO_W = 16;
  localparam int SAM_HI_W = 16;
  // Sensing time and burst
  localparam int SAM_SENSE_NS     = 96;
  localparam int SAM_CLK_NS       = 20;
  localparam int SAM_SENSE_CYC    =
    (SAM_SENSE_NS + SAM_CLK_NS - 1) / SAM_CLK_NS;
  localparam int SAM_MIN_KHZ      = 9600;
  localparam int SAM_WORDLINE_W   = 16;
  localparam int SAM_EOWL_WAIT    = 2;

  typedef struct packed {
    logic        adv_n;
    logic        oe_n;
    logic        we_n;
    logic        ce_n;
    logic        clk_rise;
    logic [15:0] ad;
  } sam_bus_t;
endpackage

// file: rtl/sam_sense.sv
// Sensing timer: a read restarts it, completion pulses done
`timescale 1ns/1ns
module sam_sense #(
  parameter int CYC = sam_pkg::SAM_SENSE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_reg <= 8'(CYC);
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          done_o <= 1'b1;
        end
      end
    end
  end
  assign busy_o = (cnt_reg != 8'h00);
endmodule

// file: tb/sam_core_test.sv
// Self-checking bench for the split-address mux bus logic
`timescale 1ns/1ns
module sam_core_test;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [3:0]        adr = 4'h0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic              ack;
  sam_pkg::sam_bus_t hb;
  logic [15:0]       dad;
  logic              dad_oe;
  logic              dwait;
  logic              dwait_oe;
  logic [31:0]       aaddr;
  logic              sense;
  logic              wstb;
  logic [15:0]       wdata;
  logic [15:0]       wseen = 16'h0;
  int                error_cnt = 0;
  int                compares = 0;
  int                sense_cnt = 0;
  int                s0;
  logic [31:0]       q;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  sam_host u_host (.clk_i(clk_i), .bus_o(hb));

  sam_core dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .clk_edge_i(hb.clk_rise), .address_valid_n_i(hb.adv_n),
    .oe_n_i(hb.oe_n), .we_n_i(hb.we_n), .ce_n_i(hb.ce_n),
    .ad_i(dad_oe ? dad : hb.ad), .ad_o(dad), .ad_oe_o(dad_oe),
    .wait_o(dwait), .wait_oe_o(dwait_oe),
    .array_data_i(aaddr[15:0] ^ 16'h5a5a), .array_addr_o(aaddr),
    .sense_start_o(sense), .write_strobe_o(wstb), .write_data_o(wdata));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_i) begin
    if (sense === 1'b1)
      sense_cnt++;
    if (wstb === 1'b1)
      wseen = wdata;
    if (rst_i === 1'b0)
      check(dwait_oe, dad_oe);
  end

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      check(32'h1, 32'h0);
  endtask

  // Latch lands during the phase in sync mode, a cycle after the phase ends in async mode
  task automatic addr_is(input logic [31:0] e, input int ds);
    repeat (2) @(posedge clk_i);
    check(aaddr, e);
    check(32'(sense_cnt - s0), 32'(ds));
    s0 = sense_cnt;
  endtask

  task automatic t_boot;
    wb(1'b0, sam_pkg::SAM_CFG_OFS, 32'h0);
    check(q, 32'h8000);
    check(aaddr, 32'h0);
    s0 = sense_cnt;
    u_host.apulse(1'b1, 16'h0042);
    addr_is(32'h0000_0042, 1);
    wb(1'b1, sam_pkg::SAM_CFG_OFS, 32'h8010);
    wb(1'b1, sam_pkg::SAM_UPPER_OFS, 32'hffff);
    wb(1'b0, sam_pkg::SAM_UPPER_OFS, 32'h0);
    check(q, 32'h0);
  endtask

  task automatic t_async;
    u_host.apulse(1'b0, 16'h0012);
    u_host.apulse(1'b1, 16'h3456);
    addr_is(32'h0012_3456, 1);
    u_host.set_oe(1'b0);
    repeat (10) @(posedge clk_i);
    check(dad_oe, 1'b1);
    check(dad, 16'h3456 ^ 16'h5a5a);
    check(dwait, 1'b1);
    u_host.set_oe(1'b1);
    u_host.apulse(1'b1, 16'h1111);
    u_host.apulse(1'b1, 16'h789a);
    addr_is(32'h0012_789a, 2);
    u_host.apulse(1'b1, 16'h0bcd);
    u_host.wr(16'hbeef);
    addr_is(32'h0012_0bcd, 1);
    check(wseen, 16'hbeef);
  endtask

  task automatic t_sync;
    wb(1'b1, sam_pkg::SAM_CFG_OFS, 32'h0510);
    wb(1'b0, sam_pkg::SAM_CFG_OFS, 32'h0);
    check(q, 32'h0510);
    u_host.spulse(1'b1, 16'h00ab, 16'h00cd);
    addr_is(32'h00ab_00cd, 1);
    check(dwait, 1'b1);
    u_host.set_oe(1'b0);
    repeat (10) @(posedge clk_i);
    check(dad_oe, 1'b1);
    check(dwait, 1'b0);
    check(dad, 16'h00cd ^ 16'h5a5a);
    u_host.set_oe(1'b1);
    u_host.spulse(1'b0, 16'h0, 16'h1111);
    addr_is(32'h00ab_1111, 1);
    // Valid rising with no bus clock must not latch
    u_host.apulse(1'b1, 16'h3333);
    addr_is(32'h00ab_1111, 0);
    u_host.spulse(1'b0, 16'h0, 16'h2222);
    u_host.wr(16'hcafe);
    addr_is(32'h00ab_2222, 1);
    check(wseen, 16'hcafe);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_async();
    t_sync();
    end_of_test();
  end
endmodule

// file: tb/sam_host.sv
// Host controller model that drives the multiplexed bus
`timescale 1ns/1ns
module sam_host (
  // Clock
  input  wire logic          clk_i,
  // Bus pins
  output sam_pkg::sam_bus_t  bus_o
);
  sam_pkg::sam_bus_t b = {4'hf, 1'b0, 16'h0};
  assign bus_o = b;

  // Address pulse; released bus shows the inverse, never a stale value
  task automatic apulse(input logic oe, input logic [15:0] a);
    @(posedge clk_i);
    b.ce_n  <= 1'b0;
    b.oe_n  <= oe;
    b.ad    <= a;
    b.adv_n <= 1'b0;
    @(posedge clk_i);
    b.adv_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    b.ad    <= ~a;
  endtask

  // Clocked phases; valid stays low across both
  task automatic spulse(input logic two, input logic [15:0] up,
                        input logic [15:0] lo);
    @(posedge clk_i);
    b.adv_n    <= 1'b0;
    b.clk_rise <= 1'b1;
    b.oe_n     <= !two;
    b.ad       <= two ? up : lo;
    if (two) begin
      @(posedge clk_i);
      b.oe_n <= 1'b1;
      b.ad   <= lo;
    end
    @(posedge clk_i);
    b.clk_rise <= 1'b0;
    b.adv_n    <= 1'b1;
    @(posedge clk_i);
    b.ad       <= ~lo;
  endtask

  task automatic set_oe(input logic v);
    @(posedge clk_i);
    b.oe_n <= v;
  endtask

  // Write enable pulse with no bus clock at all
  task automatic wr(input logic [15:0] d);
    @(posedge clk_i);
    b.ad   <= d;
    b.we_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    b.we_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    b.ad   <= ~d;
  endtask
endmodule
